// [inc/alarm_history_logger_map.vh]
// Constants for the alarm history logger: sizes, marker and timing counts.
// Assumes a 20 MHz system clock; included by its bare name.
`ifndef ALARM_HISTORY_LOGGER_MAP_VH
`define ALARM_HISTORY_LOGGER_MAP_VH

// ****************************************
// Sizes
// ****************************************
`define AH_DEPTH 10
`define AH_IDX_W 4
`define AH_CODE_W 12
`define AH_TIME_W 32
// Empty slot marker
`define AH_EMPTY_CODE 12'hFFF

// ****************************************
// Timing
// ****************************************
`define AH_CLK_HZ 20000000
`define AH_TICK_MS 100
`define AH_TICK_CYCLES ((`AH_CLK_HZ / 1000) * `AH_TICK_MS)
`define AH_HOUR_S 3600
`define AH_HOUR_TICKS ((`AH_HOUR_S * 1000) / `AH_TICK_MS)

// ****************************************
// Utility function requests
// ****************************************
`define AH_FN_VIEW 2'b01
`define AH_FN_CLEAR 2'b10

`endif

// [src/alarm_history_logger.v]
// Alarm history logger: ten newest alarm codes with operating-time stamps.
// Assumes inputs synchronous to mclk; the store sits in a retained domain
// that rst (alarm reset) does not touch.
`timescale 1ns/1ps
`include "alarm_history_logger_map.vh"

// How it works
// - The ten newest alarms are kept and can be read.
// - Each slot holds alarm code and time stamp, both readable.
// - Time counter ticks once per 100 ms while both supplies are on.
// - Logging an alarm copies the current time count as its stamp.
// - A 32-bit counter of 100-ms ticks runs about 13 years without wrap.
// - Same code again within one hour is dropped, else logged unless a clear request comes in the same cycle.
// - Unused slots read the empty marker code.
// - History is untouched by alarm reset and main power loss.
// - History erased only by the clear utility request.
// - Requests from both operator ports at once are refused with no_operation_indication.
module alarm_history_logger #(
	parameter TICK_CYCLES = `AH_TICK_CYCLES,
	parameter HOUR_TICKS = `AH_HOUR_TICKS
) (
	input wire mclk,
	input wire rst,
	input wire ctrl_pwr_on,
	input wire main_pwr_on,
	input wire alarm_valid,
	input wire [`AH_CODE_W-1:0] alarm_code,
	input wire [1:0] panel_fn_req,
	input wire [1:0] tool_fn_req,
	input wire [`AH_IDX_W-1:0] rd_index,
	output reg [`AH_CODE_W-1:0] rd_code_ff,
	output reg [`AH_TIME_W-1:0] rd_stamp_ff,
	output reg rd_valid_ff,
	output reg no_operation_indication_ff,
	output reg clear_done_ff,
	output reg [`AH_TIME_W-1:0] op_time_ff
);

	// ****************************************
	// Operating-time counter
	// ****************************************
	reg [31:0] div_ff;
	reg tick_ff;
	// Sized copies of the counts, cut to the widths they are compared at
	localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
	localparam [`AH_TIME_W-1:0] HOUR_LIM = HOUR_TICKS;
	// No reset on the time base
	// Held in retained storage like the history, so time keeps accumulating.
	initial begin
		div_ff = 32'h0000_0000;
		tick_ff = 1'b0;
		op_time_ff = {`AH_TIME_W{1'b0}};
	end

	always @(posedge mclk) begin
		tick_ff <= 1'b0;
		if (ctrl_pwr_on && main_pwr_on) begin
			if (div_ff == TICK_LAST) begin
				div_ff <= 32'h0000_0000;
				tick_ff <= 1'b1;
			end else begin
				div_ff <= div_ff + 32'h0000_0001;
			end
		end
	end

	always @(posedge mclk) begin
		if (tick_ff) begin
			op_time_ff <= op_time_ff + {{(`AH_TIME_W-1){1'b0}}, 1'b1};
		end
	end

	// ****************************************
	// Utility arbitration
	// ****************************************
	wire panel_any = |panel_fn_req;
	wire tool_any = |tool_fn_req;
	wire both_req = panel_any && tool_any;
	wire [1:0] fn_req = panel_any ? panel_fn_req : tool_fn_req;
	wire clear_req = !both_req && (fn_req == `AH_FN_CLEAR);
	wire view_req = !both_req && (fn_req == `AH_FN_VIEW);

	// ****************************************
	// History store
	// ****************************************
	// Entry 0 is always the newest; shifting costs area but keeps reads trivial.
	reg [`AH_CODE_W-1:0] code_ff [0:`AH_DEPTH-1];
	reg [`AH_TIME_W-1:0] stamp_ff [0:`AH_DEPTH-1];
	reg used_ff [0:`AH_DEPTH-1];
	integer k;

	initial begin
		for (k = 0; k < `AH_DEPTH; k = k + 1) begin
			used_ff[k] = 1'b0;
			code_ff[k] = `AH_EMPTY_CODE;
			stamp_ff[k] = {`AH_TIME_W{1'b0}};
		end
	end

	// ****************************************
	// Repeat filter
	// ****************************************
	// Repeat within one hour
	// Only the newest stored copy of a code decides; older copies are masked.
	wire [`AH_DEPTH-1:0] hit;
	wire [`AH_DEPTH-1:0] young;
	wire [`AH_DEPTH-1:0] first_young;
	wire [`AH_DEPTH:0] seen;
	assign seen[0] = 1'b0;
	genvar g;
	generate
		for (g = 0; g < `AH_DEPTH; g = g + 1) begin : gen_match
			wire [`AH_TIME_W-1:0] age;
			// Unsigned difference stays right across counter growth
			assign age = op_time_ff - stamp_ff[g];
			assign hit[g] = used_ff[g] && (code_ff[g] == alarm_code);
			assign young[g] = (age <= HOUR_LIM);
			assign first_young[g] = hit[g] && !seen[g] && young[g];
			assign seen[g+1] = seen[g] | hit[g];
		end
	endgenerate

	wire recent_dup = |first_young;
	wire log_now = alarm_valid && !recent_dup && !clear_req;

	// ****************************************
	// Slot shift chain
	// ****************************************
	// Store not on rst
	// Alarm reset must not erase history, so rst is deliberately unused here.
	generate
		for (g = 0; g < `AH_DEPTH; g = g + 1) begin : gen_slot
			wire [`AH_CODE_W-1:0] in_code;
			wire [`AH_TIME_W-1:0] in_stamp;
			wire in_used;
			if (g == 0) begin : gen_head
				assign in_code = alarm_code;
				assign in_stamp = op_time_ff;
				assign in_used = 1'b1;
			end else begin : gen_tail
				assign in_code = code_ff[g-1];
				assign in_stamp = stamp_ff[g-1];
				assign in_used = used_ff[g-1];
			end
			always @(posedge mclk) begin
				if (clear_req) begin
					used_ff[g] <= 1'b0;
					code_ff[g] <= `AH_EMPTY_CODE;
					stamp_ff[g] <= {`AH_TIME_W{1'b0}};
				end else if (log_now) begin
					used_ff[g] <= in_used;
					code_ff[g] <= in_code;
					stamp_ff[g] <= in_stamp;
				end
			end
		end
	endgenerate

	// ****************************************
	// Readout and status
	// ****************************************
	always @(posedge mclk) begin
		if (rst) begin
			rd_code_ff <= `AH_EMPTY_CODE;
			rd_stamp_ff <= {`AH_TIME_W{1'b0}};
			rd_valid_ff <= 1'b0;
			no_operation_indication_ff <= 1'b0;
			clear_done_ff <= 1'b0;
		end else begin
			no_operation_indication_ff <= both_req;
			clear_done_ff <= clear_req;
			rd_valid_ff <= view_req;
			if (view_req && rd_index < `AH_DEPTH && used_ff[rd_index]) begin
				rd_code_ff <= code_ff[rd_index];
				rd_stamp_ff <= stamp_ff[rd_index];
			end else begin
				rd_code_ff <= `AH_EMPTY_CODE;
				rd_stamp_ff <= {`AH_TIME_W{1'b0}};
			end
		end
	end

endmodule

// [verification/op_port.sv]
// Operator port model: panel or setup tool.
// Assumes cmd changes at the falling clock edge.
`timescale 1ns/1ps
module op_port (
	input wire [1:0] cmd,
	output wire [1:0] fn_req
);
	assign fn_req = cmd;
endmodule

// [verification/alarm_history_logger_sva.sv]
// Port checker for the alarm history logger.
// Bound to the top module; one clock, rst masks all.
`timescale 1ns/1ps
module alarm_history_logger_sva (
	input wire mclk,
	input wire rst,
	input wire [1:0] panel_fn_req,
	input wire [1:0] tool_fn_req,
	input wire [11:0] rd_code_ff,
	input wire rd_valid_ff,
	input wire no_operation_indication_ff,
	input wire clear_done_ff,
	input wire [31:0] op_time_ff
);
	wire [1:0] q = panel_fn_req | tool_fn_req;
	wire two = |panel_fn_req && |tool_fn_req;
	wire vw = !two && q == 2'b01;
	wire cl = !two && q == 2'b10;
	wire nop = no_operation_indication_ff;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_noop_set: assert property (two |=> nop) else $error("noop");
	chk_noop_cause: assert property (nop |-> $past(two)) else $error("noop");
	chk_view_answer: assert property (vw |=> rd_valid_ff) else $error("view");
	chk_view_cause: assert property (rd_valid_ff |-> $past(vw)) else $error("view");
	chk_clear_answer: assert property (cl |=> clear_done_ff) else $error("clear");
	chk_clear_cause: assert property (clear_done_ff |-> $past(cl)) else $error("clear");
	chk_clear_empty: assert property (cl ##1 vw |=> rd_code_ff == 12'hFFF) else $error("empty");
	chk_time_step: assert property ($changed(op_time_ff) |->
		op_time_ff == $past(op_time_ff) + 1) else $error("time");
endmodule
bind alarm_history_logger alarm_history_logger_sva alarm_history_logger_sva_inst (.*);

// [verification/tb_alarm_history_logger.sv]
// Scenario bench for the alarm history logger.
// Needs op_port and the bound checker.
`timescale 1ns/1ps
`include "alarm_history_logger_map.vh"
module tb_alarm_history_logger;
	reg mclk = 0, rst = 1, ctrl_pwr_on = 1, main_pwr_on = 1, alarm_valid = 0;
	reg [11:0] alarm_code = 0;
	reg [3:0] rd_index = 0;
	reg [1:0] pc = 0, tc = 0;
	reg [31:0] s0, s1;
	wire [1:0] panel_fn_req, tool_fn_req;
	wire [11:0] rd_code_ff;
	wire [31:0] rd_stamp_ff, op_time_ff;
	wire rd_valid_ff, no_operation_indication_ff, clear_done_ff;
	int miscompares = 0, checks_done = 0, cyc = 0;
	always #25 mclk = ~mclk;
	op_port panel_port (.cmd(pc), .fn_req(panel_fn_req));
	op_port tool_port (.cmd(tc), .fn_req(tool_fn_req));
	// Short tick and hour keep the run brief
	alarm_history_logger #(.TICK_CYCLES(4), .HOUR_TICKS(5)) alarm_history_logger_inst (.*);
	task chk(input bit ok);
		checks_done++;
		miscompares += !ok;
		if (!ok) $display("ERROR %0t bad answer", $time);
	endtask
	task alarm(input [11:0] c);
		alarm_valid = 1;
		alarm_code = c;
		@(negedge mclk) alarm_valid = 0;
		@(negedge mclk);
	endtask
	task view(input [3:0] i, input [11:0] c);
		pc = `AH_FN_VIEW;
		rd_index = i;
		@(negedge mclk) pc = 0;
		chk(rd_valid_ff === 1 && rd_code_ff === c);
		s0 = rd_stamp_ff;
		@(negedge mclk);
	endtask
	task t_log;
		alarm(1);
		repeat (6) @(negedge mclk);
		alarm(2);
		view(1, 1);
		s1 = s0;
		view(0, 2);
		chk(s0 - s1 === 2);
		alarm(2);
		view(1, 1);
		repeat (28) @(negedge mclk);
		alarm(2);
		view(1, 2);
		$display("t_log done");
	endtask
	task t_fill;
		for (int i = 3; i < 14; i++) alarm(i);
		view(0, 13);
		view(9, 4);
		$display("t_fill done");
	endtask
	task t_power;
		ctrl_pwr_on = 0;
		repeat (2) @(negedge mclk);
		s0 = op_time_ff;
		repeat (12) @(negedge mclk);
		chk(op_time_ff === s0);
		ctrl_pwr_on = 1;
		main_pwr_on = 0;
		repeat (12) @(negedge mclk);
		chk(op_time_ff === s0);
		main_pwr_on = 1;
		repeat (9) @(negedge mclk);
		chk(op_time_ff - s0 === 2);
		$display("t_power done");
	endtask
	task t_guard;
		pc = `AH_FN_VIEW;
		tc = `AH_FN_CLEAR;
		@(negedge mclk) tc = 0;
		pc = 0;
		chk(no_operation_indication_ff === 1 && clear_done_ff === 0);
		rst = 1;
		repeat (3) @(negedge mclk);
		rst = 0;
		view(0, 13);
		tc = `AH_FN_CLEAR;
		@(negedge mclk) tc = 0;
		chk(clear_done_ff === 1);
		view(0, `AH_EMPTY_CODE);
		chk(s0 === 0);
		view(15, `AH_EMPTY_CODE);
		$display("t_guard done");
	endtask
	task summarize;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Ceiling far above the roughly 140 cycles needed
	always @(posedge mclk) begin
		cyc++;
		miscompares += (cyc == 1000);
		if (cyc == 1000) summarize;
	end
	initial begin
		repeat (20) @(negedge mclk);
		rst = 0;
		t_log;
		t_fill;
		t_power;
		t_guard;
		summarize;
	end
endmodule
